// ==== rtl/ssi_shadow_unit.sv ====
// shadow-set selection and interrupt-mode control with an AXI4-Lite slave
// assumes one clock clk_sys, synchronous reset, static ext_ctrl_present_in
//
// Chosen here: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
// Overview of operation
// [RULE_01] six hardware, two software, one timer interrupt
// [RULE_02] compatibility, vectored and external-controller modes
// [RULE_03] vectored mode always present, bit reads one
// [RULE_04] external-controller bit follows static input
// [RULE_05] reset enters compatibility mode
// [RULE_06] one to eight banks, highest index reported
// [RULE_07] highest index zero means normal bank only
// [RULE_08] normal registers are bank zero
// [RULE_09] references redirected to the current bank
// [RULE_10] privileged cross-bank register read and write
// [RULE_11] control holds current and previous bank
// [RULE_12] vectored mode bank from mapping register; mapReg covers vectors 0 to 7 only, the timer vector 8 reads past it
// [RULE_13] external controller supplies bank number
// [RULE_14] exceptions use software exception bank field
// [RULE_15] entry saves current, loads new bank
// [RULE_16] exception return restores previous bank
// [RULE_17] user, kernel, debug; handlers run kernel
// [RULE_18] unmasked request raises interrupt exception
// [RULE_19] register file uses current bank immediately
module ssi_shadow_unit
    import ssi_pkg::*;
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [NUM_HW_INT-1:0] hwIntIn,
    input wire logic timerIntIn,
    input wire logic ext_ctrl_present_in,
    input wire logic [SET_W-1:0] extSetIn,
    input wire logic excEntry,
    input wire logic excIsInt,
    input wire logic exception_return,
    input wire logic debugEntry,
    input wire logic debugReturn,
    input wire logic [4:0] gprRdAddrA,
    input wire logic [4:0] gprRdAddrB,
    output logic [31:0] gprRdDataA,
    output logic [31:0] gprRdDataB,
    input wire logic gprWrEn,
    input wire logic [4:0] gprWrAddr,
    input wire logic [31:0] gprWrData,
    input wire logic read_prev_set_gpr,
    input wire logic write_prev_set_gpr,
    input wire logic [4:0] prevGprAddr,
    input wire logic [31:0] prevGprWrData,
    output logic [31:0] prevGprRdData,
    output logic intRequest,
    output logic [3:0] intVector,
    output logic [SET_W-1:0] current_set,
    output logic [1:0] privMode,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    ssi_gpr_if gpr ();

    // ----------------------------------------
    // state
    // ----------------------------------------
    ssi_mode_e mode_reg;
    ssi_priv_e priv_reg;
    logic [SET_W-1:0] cssReg;
    logic [SET_W-1:0] pssReg;
    logic [SET_W-1:0] essReg;
    logic [31:0] mapReg;
    logic [NUM_INT-1:0] maskReg;
    logic [NUM_SW_INT-1:0] swReqReg;
    logic [4:0] selRegReg;
    logic [SET_W-1:0] selBankReg;
    logic [SET_W-1:0] cssNext;
    logic [NUM_INT-1:0] pending;
    logic [3:0] vecNum;
    logic [SET_W-1:0] entrySet;
    logic wrSetCtl;
    logic wrGprWord;
    logic rdGprWord;
    logic [31:0] wd;

    // ----------------------------------------
    // interrupt sources
    // ----------------------------------------
    // [RULE_01] nine request lines
    assign pending = {timerIntIn, hwIntIn, swReqReg} & maskReg;
    // [RULE_18] any unmasked request
    assign intRequest = |pending;

    // highest line wins, as in vectored priority order
    always_comb begin
        vecNum = 4'h0;
        for (int i = 0; i < NUM_INT; i++) begin
            if (pending[i]) begin
                vecNum = 4'(i);
            end
        end
    end
    assign intVector = vecNum;

    // ----------------------------------------
    // bank selection
    // ----------------------------------------
    always_comb begin
        entrySet = essReg;
        if (excIsInt) begin
            unique case (mode_reg)
                // [RULE_12] vectored mapping
                MODE_VECTORED: entrySet = mapReg[vecNum*4 +: SET_W];
                // [RULE_13] controller supplied set
                MODE_EXTCTRL: entrySet = extSetIn;
                // [RULE_14] non-vectored uses exception set
                MODE_COMPAT: entrySet = essReg;
                default: entrySet = essReg;
            endcase
        end
        // [RULE_07] sets above the highest implemented one fall back to bank zero
        if (entrySet > HIGHEST_SET) begin
            entrySet = SET_ZERO;
        end
    end

    always_comb begin
        cssNext = cssReg;
        if (excEntry) begin
            cssNext = entrySet;
        end else if (exception_return) begin
            cssNext = pssReg;
        end
    end

    // [RULE_15] save and load on entry
    // [RULE_16] restore on return
    // [RULE_08] bank zero after reset
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            cssReg <= SET_ZERO;
            pssReg <= SET_ZERO;
        end else begin
            cssReg <= cssNext;
            if (excEntry) begin
                pssReg <= cssReg;
            end else if (wrSetCtl) begin
                pssReg <= wd[PSS_LSB +: SET_W];
            end
        end
    end

    // [RULE_19] file indexed by the updating bank
    assign gpr.curBank = cssNext;
    assign current_set = cssReg;

    // [RULE_17] privilege tracking
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            priv_reg <= PRIV_KERNEL;
        end else if (debugEntry) begin
            priv_reg <= PRIV_DEBUG;
        end else if (debugReturn) begin
            priv_reg <= PRIV_KERNEL;
        end else if (excEntry) begin
            priv_reg <= PRIV_KERNEL;
        end else if (exception_return) begin
            priv_reg <= PRIV_USER;
        end
    end
    assign privMode = priv_reg;

    // ----------------------------------------
    // register file hookup
    // ----------------------------------------
    assign gpr.rdAddrA = gprRdAddrA;
    assign gpr.rdAddrB = gprRdAddrB;
    assign gprRdDataA = gpr.rdDataA;
    assign gprRdDataB = gpr.rdDataB;
    assign gpr.wrEn = gprWrEn;
    assign gpr.wrAddr = gprWrAddr;
    assign gpr.wrData = gprWrData;
    // [RULE_10] cross-bank access uses previous set, bus register-data access the selected bank; both use it when one reads and the other writes in one cycle
    assign gpr.xRdEn = read_prev_set_gpr || rdGprWord;
    assign gpr.xWrEn = write_prev_set_gpr || wrGprWord;
    assign gpr.xBank = (rdGprWord || wrGprWord) ? selBankReg : pssReg;
    assign gpr.xAddr = (rdGprWord || wrGprWord) ? selRegReg : prevGprAddr;
    assign gpr.xWrData = wrGprWord ? s_axi_wdata : prevGprWrData;
    assign prevGprRdData = gpr.xRdData;

    ssi_bank_rf u_rf (
        .clk_sys(clk_sys),
        .gpr(gpr)
    );

    // ----------------------------------------
    // axi4-lite write
    // ----------------------------------------
    logic awHeld;
    logic wHeld;
    logic [7:0] awAddrReg;
    logic doWrite;
    logic [7:0] wAddr;

    assign s_axi_awready = !awHeld && !s_axi_bvalid;
    assign s_axi_wready = !wHeld && !s_axi_bvalid;
    assign wAddr = awHeld ? awAddrReg : s_axi_awaddr;
    // write happens once both halves are present
    assign doWrite = (awHeld || (s_axi_awvalid && s_axi_awready)) &&
                     (wHeld || (s_axi_wvalid && s_axi_wready));
    assign wrSetCtl = doWrite && wAddr == ADDR_SETCTL && s_axi_wstrb[1];
    // the data lane is only guaranteed valid in the cycle it is taken
    assign wrGprWord = doWrite && !wHeld && wAddr == ADDR_GPRDATA &&
                       (&s_axi_wstrb) && !write_prev_set_gpr;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            awAddrReg <= 8'h00;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            if (doWrite) begin
                awHeld <= 1'b0;
                wHeld <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (wAddr > ADDR_GPRDATA || wAddr[1:0] != 2'b00) ?
                               RESP_SLVERR : RESP_OKAY;
            end else begin
                if (s_axi_awvalid && s_axi_awready) begin
                    awHeld <= 1'b1;
                    awAddrReg <= s_axi_awaddr;
                end
                if (s_axi_wvalid && s_axi_wready) begin
                    wHeld <= 1'b1;
                end
                if (s_axi_bvalid && s_axi_bready) begin
                    s_axi_bvalid <= 1'b0;
                end
            end
        end
    end

    // wdata is held by the master until wready, so a held beat needs a copy
    logic [31:0] wDataReg;
    logic [3:0] wStrbReg;
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            wDataReg <= 32'h0000_0000;
            wStrbReg <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            wDataReg <= s_axi_wdata;
            wStrbReg <= s_axi_wstrb;
        end
    end

    assign wd = wHeld ? wDataReg : s_axi_wdata;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            // [RULE_05] compatibility mode after reset
            mode_reg <= MODE_COMPAT;
            maskReg <= MASK_RESET;
            swReqReg <= '0;
            essReg <= SET_ZERO;
            mapReg <= MAP_RESET;
            selRegReg <= 5'h00;
            selBankReg <= SET_ZERO;
        end else if (doWrite) begin
            unique case (wAddr)
                ADDR_INTCTL: begin
                    // [RULE_02] mode select, only advertised modes
                    if (wd[MODE_LSB +: 2] == MODE_EXTCTRL && ext_ctrl_present_in) begin
                        mode_reg <= MODE_EXTCTRL;
                    end else if (wd[MODE_LSB +: 2] == MODE_VECTORED) begin
                        mode_reg <= MODE_VECTORED;
                    end else begin
                        mode_reg <= MODE_COMPAT;
                    end
                    maskReg <= wd[MASK_LSB +: NUM_INT];
                    swReqReg <= wd[SWREQ_LSB +: NUM_SW_INT];
                end
                // [RULE_14] software exception set
                ADDR_SETCTL: essReg <= wd[ESS_LSB +: SET_W];
                // [RULE_12] vector to set map
                ADDR_SETMAP: mapReg <= wd;
                ADDR_BANKSEL: begin
                    selRegReg <= wd[SEL_REG_LSB +: 5];
                    selBankReg <= wd[SEL_BANK_LSB +: SET_W];
                end
                default: begin
                end
            endcase
        end
    end

    // ----------------------------------------
    // axi4-lite read
    // ----------------------------------------
    logic rdPend;
    logic [31:0] rdMux;
    assign s_axi_arready = !s_axi_rvalid && !rdPend;
    assign rdGprWord = s_axi_arvalid && s_axi_arready &&
                       s_axi_araddr == ADDR_GPRDATA && !read_prev_set_gpr;

    always_comb begin
        rdMux = 32'h0000_0000;
        unique case (s_axi_araddr)
            ADDR_CONFIG_WORD_THREE: begin
                // [RULE_03] vectored mode always advertised
                rdMux[VECTOR_INT_PRESENT_BIT_BIT] = 1'b1;
                // [RULE_04] follows the static input
                rdMux[EXT_CTRL_PRESENT_BIT_BIT] = ext_ctrl_present_in;
            end
            ADDR_SETCTL: begin
                // [RULE_11] current and previous set fields
                // [RULE_06] highest implemented set
                rdMux[HSS_LSB +: SET_W] = HIGHEST_SET;
                rdMux[ESS_LSB +: SET_W] = essReg;
                rdMux[PSS_LSB +: SET_W] = pssReg;
                rdMux[CSS_LSB +: SET_W] = cssReg;
            end
            ADDR_SETMAP: rdMux = mapReg;
            ADDR_INTCTL: begin
                rdMux[MODE_LSB +: 2] = mode_reg;
                rdMux[MASK_LSB +: NUM_INT] = maskReg;
                rdMux[SWREQ_LSB +: NUM_SW_INT] = swReqReg;
            end
            ADDR_STATUS: begin
                rdMux[PRIV_LSB +: 2] = priv_reg;
                rdMux[PEND_LSB +: NUM_INT] = pending;
            end
            ADDR_BANKSEL: begin
                rdMux[SEL_REG_LSB +: 5] = selRegReg;
                rdMux[SEL_BANK_LSB +: SET_W] = selBankReg;
            end
            default: rdMux = 32'h0000_0000;
        endcase
    end

    // a register-file read needs one extra cycle for the array port
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            rdPend <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else if (rdPend) begin
            rdPend <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= gpr.xRdData;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rdPend <= rdGprWord;
            s_axi_rvalid <= !rdGprWord;
            s_axi_rdata <= rdMux;
            s_axi_rresp <= (s_axi_araddr > ADDR_GPRDATA || s_axi_araddr[1:0] != 2'b00 ||
                            (s_axi_araddr == ADDR_GPRDATA && !rdGprWord)) ?
                           RESP_SLVERR : RESP_OKAY;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    entry_save_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RULE_15]
        excEntry |=> pssReg == $past(cssReg) && cssReg == $past(entrySet))
        else $error("entry did not save and load set");
    exception_return_restore_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RULE_16]
        exception_return && !excEntry |=> cssReg == $past(pssReg))
        else $error("return did not restore set");
    reset_compat_a: assert property (@(posedge clk_sys) // [RULE_05]
        sys_rst |=> mode_reg == MODE_COMPAT && cssReg == SET_ZERO)
        else $error("reset did not select compatibility mode");
    int_raise_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RULE_18]
        intRequest == (|({timerIntIn, hwIntIn, swReqReg} & maskReg)))
        else $error("interrupt request mismatch");
    vec_map_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RULE_12]
        excEntry && excIsInt && mode_reg == MODE_VECTORED
        |=> cssReg == $past(mapReg[vecNum*4 +: SET_W]))
        else $error("vectored set not from map");
    ext_set_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RULE_13]
        excEntry && excIsInt && mode_reg == MODE_EXTCTRL && extSetIn <= HIGHEST_SET
        |=> cssReg == $past(extSetIn))
        else $error("controller set not used");
    ess_set_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RULE_14]
        excEntry && !excIsInt |=> cssReg == $past(essReg))
        else $error("exception set not used");
    eic_gate_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RULE_04]
        mode_reg == MODE_EXTCTRL |-> ext_ctrl_present_in)
        else $error("controller mode without controller");
    kernel_entry_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RULE_17]
        excEntry && !debugEntry |=> priv_reg == PRIV_KERNEL)
        else $error("handler not in kernel mode");
endmodule : ssi_shadow_unit

// ==== rtl/ssi_pkg.sv ====
// shared constants and types for the shadow-set / interrupt-mode unit
// assumes a single 200 MHz core clock and a synchronous active-high reset
package ssi_pkg;
    // ----------------------------------------
    // register map (byte addresses)
    // ----------------------------------------
    localparam logic [7:0] ADDR_CONFIG_WORD_THREE = 8'h00;
    localparam logic [7:0] ADDR_SETCTL = 8'h04;
    localparam logic [7:0] ADDR_SETMAP = 8'h08;
    localparam logic [7:0] ADDR_INTCTL = 8'h0c;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_BANKSEL = 8'h14;
    localparam logic [7:0] ADDR_GPRDATA = 8'h18;
    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int VECTOR_INT_PRESENT_BIT_BIT = 5;
    localparam int EXT_CTRL_PRESENT_BIT_BIT = 6;
    localparam int HSS_LSB = 26;
    localparam int ESS_LSB = 12;
    localparam int PSS_LSB = 6;
    localparam int CSS_LSB = 0;
    localparam int MODE_LSB = 0;
    localparam int MASK_LSB = 8;
    localparam int PEND_LSB = 8;
    localparam int PRIV_LSB = 0;
    localparam int SWREQ_LSB = 16;
    localparam int SEL_REG_LSB = 0;
    localparam int SEL_BANK_LSB = 8;
    // ----------------------------------------
    // sizes and reset values
    // ----------------------------------------
    localparam int NUM_HW_INT = 6;
    localparam int NUM_SW_INT = 2;
    localparam int NUM_INT = 9;
    localparam int NUM_BANKS = 8;
    localparam int SET_W = 4;
    localparam logic [SET_W-1:0] HIGHEST_SET = 4'h7;
    localparam logic [SET_W-1:0] SET_ZERO = 4'h0;
    localparam logic [NUM_INT-1:0] MASK_RESET = 9'h000;
    localparam logic [31:0] MAP_RESET = 32'h0000_0000;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [1:0] {
        MODE_COMPAT = 2'b00,
        MODE_VECTORED = 2'b01,
        MODE_EXTCTRL = 2'b11
    } ssi_mode_e;

    typedef enum logic [1:0] {
        PRIV_USER = 2'b00,
        PRIV_KERNEL = 2'b01,
        PRIV_DEBUG = 2'b11
    } ssi_priv_e;
endpackage : ssi_pkg

// ==== rtl/ssi_gpr_if.sv ====
// bundle between the control top and the banked register file
// assumes both ends share clk_sys
`timescale 1ns/1ps
interface ssi_gpr_if;
    import ssi_pkg::*;
    logic [SET_W-1:0] curBank;
    logic [4:0] rdAddrA;
    logic [4:0] rdAddrB;
    logic [31:0] rdDataA;
    logic [31:0] rdDataB;
    logic wrEn;
    logic [4:0] wrAddr;
    logic [31:0] wrData;
    logic xRdEn;
    logic [SET_W-1:0] xBank;
    logic [4:0] xAddr;
    logic [31:0] xRdData;
    logic xWrEn;
    logic [31:0] xWrData;
    modport ctl (output curBank, rdAddrA, rdAddrB, wrEn, wrAddr, wrData,
                 xRdEn, xBank, xAddr, xWrEn, xWrData,
                 input rdDataA, rdDataB, xRdData);
    modport rf (input curBank, rdAddrA, rdAddrB, wrEn, wrAddr, wrData,
                xRdEn, xBank, xAddr, xWrEn, xWrData,
                output rdDataA, rdDataB, xRdData);
endinterface : ssi_gpr_if

// ==== rtl/ssi_bank_rf.sv ====
// banked general-purpose register file, one copy per shadow set
// assumes the control block supplies bank and ports on clk_sys
`timescale 1ns/1ps
module ssi_bank_rf
    import ssi_pkg::*;
(
    input wire logic clk_sys,
    ssi_gpr_if.rf gpr
);
    logic [31:0] regs [NUM_BANKS*32];
    logic [7:0] wIdx;
    logic [7:0] xIdx;

    assign wIdx = {gpr.curBank[2:0], gpr.wrAddr};
    assign xIdx = {gpr.xBank[2:0], gpr.xAddr};

    // [RULE_09] redirect to current bank
    // register zero of every bank reads as zero
    assign gpr.rdDataA = (gpr.rdAddrA == 5'h00) ? 32'h0000_0000 :
                         regs[{gpr.curBank[2:0], gpr.rdAddrA}];
    assign gpr.rdDataB = (gpr.rdAddrB == 5'h00) ? 32'h0000_0000 :
                         regs[{gpr.curBank[2:0], gpr.rdAddrB}];

    always_ff @(posedge clk_sys) begin
        if (gpr.xWrEn && gpr.xAddr != 5'h00) begin
            regs[xIdx] <= gpr.xWrData;
        end else if (gpr.wrEn && gpr.wrAddr != 5'h00) begin
            regs[wIdx] <= gpr.wrData;
        end
    end

    // [RULE_10] cross-bank read port
    always_ff @(posedge clk_sys) begin
        if (gpr.xRdEn) begin
            gpr.xRdData <= (gpr.xAddr == 5'h00) ? 32'h0000_0000 : regs[xIdx];
        end
    end
endmodule : ssi_bank_rf

// ==== sim/ssi_eic_model.sv ====
// behavioural external interrupt controller facing the shadow-set unit
// assumes clk_sys from the bench; slow delays the bank answer one cycle
`timescale 1ns/1ps
module ssi_eic_model
    import ssi_pkg::*;
(
    input wire logic clk_sys,
    input wire logic slow,
    input wire logic [3:0] intVector,
    output logic [SET_W-1:0] extSetIn,
    output logic presentOut
);
    logic [SET_W-1:0] stage;
    assign presentOut = 1'h1;
    always_ff @(posedge clk_sys) begin
        stage <= {1'h0, intVector[2:0] ^ 3'h5};
        extSetIn <= slow ? stage : {1'h0, intVector[2:0] ^ 3'h5};
    end
endmodule : ssi_eic_model

// ==== sim/shadow_set_interrupt_mode_tb.sv ====
// self-checking bench: drivers queue notes, a monitor compares reads
// assumes ssi_eic_model as far side and a 200 MHz clock
`timescale 1ns/1ps
module shadow_set_interrupt_mode_tb;
    import ssi_pkg::*;
    typedef struct {string nm; logic [33:0] v; logic [33:0] m;} ssi_note_s;
    ssi_note_s notes[$];
    ssi_note_s nt;
    int bad_count = 0;
    int total_checks = 0;
    int k;
    logic [31:0] d0, d1, map;
    logic clk_sys = 0, sys_rst = 1, timerIntIn = 0, excEntry = 0, excIsInt = 0, slow = 0;
    logic exception_return = 0, debugEntry = 0, debugReturn = 0, gprWrEn = 0;
    logic read_prev_set_gpr = 0, write_prev_set_gpr = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
    logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0, ext_ctrl_present_in;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, intRequest;
    logic [NUM_HW_INT-1:0] hwIntIn = 0;
    logic [SET_W-1:0] extSetIn, current_set;
    logic [4:0] gprRdAddrA = 5, gprRdAddrB = 5, gprWrAddr = 5, prevGprAddr = 5;
    logic [31:0] gprWrData = 0, prevGprWrData = 0, s_axi_wdata = 0, gprRdDataA, gprRdDataB;
    logic [31:0] prevGprRdData, s_axi_rdata;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [3:0] s_axi_wstrb = 4'hf, intVector, hs;
    logic [1:0] privMode, s_axi_bresp, s_axi_rresp;
    assign hs = {s_axi_bvalid, s_axi_awready & s_axi_wready, s_axi_arready, s_axi_rvalid};
    always #2.5 clk_sys = ~clk_sys;
    ssi_shadow_unit i_dut (.clk_sys, .sys_rst, .hwIntIn, .timerIntIn, .ext_ctrl_present_in,
        .extSetIn, .excEntry, .excIsInt, .exception_return, .debugEntry, .debugReturn,
        .gprRdAddrA, .gprRdAddrB, .gprRdDataA, .gprRdDataB, .gprWrEn, .gprWrAddr, .gprWrData,
        .read_prev_set_gpr, .write_prev_set_gpr, .prevGprAddr, .prevGprWrData, .prevGprRdData,
        .intRequest, .intVector, .current_set, .privMode, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    ssi_eic_model i_eic (.clk_sys, .slow, .intVector, .extSetIn,
        .presentOut(ext_ctrl_present_in));
    // ----------------------------------------
    // bus and check tasks
    // ----------------------------------------
    task automatic chk(string nm, logic [33:0] got, logic [33:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected %s exp %h got %h", nm, exp, got);
        end
    endtask : chk
    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_sim
    // bounded wait on one handshake bit, sampled before the edge's updates land
    task automatic waitHi(int i);
        repeat (40) begin
            @(posedge clk_sys);
            if (hs[i] === 1'h1) return;
        end
        bad_count++;
        end_sim();
    endtask : waitHi
    // slave readies both halves together when idle, so both are released together
    task automatic wr(logic [7:0] a, logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        waitHi(2);
        s_axi_awvalid <= 1'h0;
        s_axi_wvalid <= 1'h0;
        s_axi_bready <= 1'h1;
        waitHi(3);
        s_axi_bready <= 1'h0;
    endtask : wr
    task automatic rd(logic [7:0] a, logic [33:0] e, logic [33:0] m, string nm);
        notes.push_back('{nm, e, m});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        waitHi(1);
        s_axi_arvalid <= 1'h0;
        s_axi_rready <= 1'h1;
        waitHi(0);
        s_axi_rready <= 1'h0;
    endtask : rd
    // k: 0 entry, 1 return, 2 debug entry, 3 cross-bank read
    task automatic pulse(int k);
        {read_prev_set_gpr, debugEntry, exception_return, excEntry} <= 4'(1 << k);
        @(posedge clk_sys);
        {read_prev_set_gpr, debugEntry, exception_return, excEntry} <= 4'h0;
        @(posedge clk_sys);
    endtask : pulse
    task automatic gw(logic [31:0] d);
        gprWrData <= d;
        gprWrEn <= 1'h1;
        @(posedge clk_sys);
        gprWrEn <= 1'h0;
        @(posedge clk_sys);
    endtask : gw
    always @(posedge clk_sys) begin
        if (s_axi_rvalid && s_axi_rready) begin
            nt = notes.pop_front();
            chk(nt.nm, {s_axi_rresp, s_axi_rdata} & nt.m, nt.v);
        end
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(32'h70c53044));
        d0 = $urandom();
        d1 = ~d0;
        repeat (8) @(posedge clk_sys);
        sys_rst <= 1'h0;
        @(posedge clk_sys);
        rd(ADDR_CONFIG_WORD_THREE, 34'h60, 34'h3_00000060, "config");
        rd(ADDR_INTCTL, 34'h0, 34'h3_00000003, "mode");
        rd(ADDR_SETCTL, 34'h1c000000, 34'h3_3c00000f, "setctl");
        rd(8'h1c, {RESP_SLVERR, 32'h0}, 34'h3_00000000, "unmapped");
        gw(d0);
        wr(ADDR_SETCTL, 32'h3000);
        excIsInt <= 1'h0;
        pulse(0);
        chk("exc set", current_set, 4'h3);
        rd(ADDR_SETCTL, 34'h3003, 34'h3_0000f3cf, "saved");
        gw(d1);
        chk("bank data", gprRdDataA, d1);
        pulse(3);
        chk("prev data", prevGprRdData, d0);
        pulse(1);
        chk("return", {current_set, gprRdDataA}, {4'h0, d0});
        wr(ADDR_INTCTL, 32'h0000ff01);
        timerIntIn <= 1'h1;
        repeat (2) @(posedge clk_sys);
        chk("masked", intRequest, 1'h0);
        timerIntIn <= 1'h0;
        for (k = 0; k < NUM_HW_INT; k++) begin
            map = $urandom() & 32'h7777_7777;
            wr(ADDR_SETMAP, map);
            hwIntIn <= 6'(1 << k);
            repeat (2) @(posedge clk_sys);
            chk("request", {intRequest, intVector}, {1'h1, 4'(k + 2)});
            excIsInt <= 1'h1;
            pulse(0);
            chk("vec set", current_set, {1'h0, map[4 * (k + 2) +: 3]});
            pulse(1);
            hwIntIn <= '0;
        end
        wr(ADDR_INTCTL, 32'h0000ff03);
        slow <= 1'h1;
        hwIntIn <= 6'h20;
        repeat (4) @(posedge clk_sys);
        pulse(0);
        chk("ext set", current_set, 4'h2);
        pulse(2);
        chk("priv", privMode, PRIV_DEBUG);
        end_sim();
    end
endmodule : shadow_set_interrupt_mode_tb
